// ### serial_module_spi_core_bench.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`include "sspi_defs.svh"
module serial_module_spi_core_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sub_clk = 1'b0, tmr_match = 1'b0, tb_sck = 1'b0;
  logic tb_cs_n = 1'b1, cs_seen = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, tick = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sck_out, sck_oe;
  logic sdo, sdo_oe, sdi, scs_n_out, scs_n_oe, done_pulse;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] cap, rd;
  logic [4:0] ntog;
  int ndone = 0, n_mismatch = 0, compares = 0;
  // Select has a pull-up; the bench plays external master when the core does not drive
  wire sck = sck_oe ? sck_out : tb_sck;
  wire scs_n = scs_n_oe ? scs_n_out : tb_cs_n;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tick <= tick + 4'h1;
    sub_clk <= tick[3];
    tmr_match <= (tick[2:0] == 3'h0);
    if (done_pulse) ndone <= ndone + 1;
    if (scs_n_oe) cs_seen <= 1'b1;
  end
  sspi_core sspi_core_i (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sub_clk, .tmr_match, .sck_in(sck), .sck_out, .sck_oe, .sdi, .sdo, .sdo_oe, .scs_n_in(scs_n), .scs_n_out,
    .scs_n_oe, .done_pulse);
  sspi_peer sspi_peer_i (.clk_sys, .sck, .sdo, .scs_n, .sdi, .cap, .ntog);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({7'h0, s_axi_bvalid}, 8'h01, "write answer");
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata[7:0];
    chk({7'h0, s_axi_rvalid}, 8'h01, "read answer");
  endtask
  task automatic wait_done(input int d0, input int lim, output int c);
    for (c = 0; c < lim && ndone == d0; c++) @(posedge clk_sys);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  task automatic t_master;
    int c, d0, h;
    logic [7:0] tx;
    for (int m = 0; m < 5; m++) begin
      tx = 8'h4B + 8'(m);
      h = 2 << (2 * m);
      axw(4'h4, 8'hFF);
      axw(4'h8, {4'h0, m[0], 3'h4});
      axw(4'h0, {m[2:0], 5'h02});
      d0 = ndone;
      axw(4'hC, tx);
      if (m == 0) axw(4'hC, 8'hFF);
      wait_done(d0, 3000, c);
      chk({3'h0, ntog}, 8'h10, "edges per byte");
      chk(cap, m[0] ? tx : rev(tx), "wire order");
      if (m < 3) chk({7'h0, c >= 16 * h - 8 && c <= 18 * h + 8}, 8'h01, "divider rate");
      axr(4'hC);
      chk(rd, tx, "received byte");
      axr(4'h8);
      chk({6'h0, rd[1:0]}, {6'h0, m == 0, 1'b1}, "done and collision");
      axw(4'h8, 8'h00);
      axw(4'h0, 8'h00);
    end
    $display("test master done");
  endtask
  task automatic t_other;
    int c, d0;
    logic [7:0] cfg [2] = '{8'h00, 8'hC2};
    axr(4'h0);
    chk(rd, `SSPI_CTRL0_RST, "control 0 reset");
    axr(4'h8);
    chk(rd, `SSPI_CTRL2_RST, "control 2 reset");
    axw(4'h8, 8'h08);
    axw(4'h0, 8'h02);
    cs_seen <= 1'b0;
    d0 = ndone;
    axw(4'hC, 8'h5A);
    wait_done(d0, 200, c);
    chk({7'h0, cs_seen}, 8'h00, "select left floating");
    for (int i = 0; i < 2; i++) begin
      axw(4'h0, cfg[i]);
      d0 = ndone;
      axw(4'hC, 8'h33);
      wait_done(d0, 100, c);
      chk({7'h0, c == 100 && !sck_oe}, 8'h01, "no transfer");
    end
    axw(4'h0, 8'h00);
    $display("test config done");
  endtask
  task automatic t_slave;
    int c, d0;
    int n [2] = '{16, 6};
    axw(4'h8, 8'h04);
    axw(4'h0, 8'hA2);
    axw(4'hC, 8'h96);
    for (int j = 0; j < 2; j++) begin
      d0 = ndone;
      @(posedge clk_sys);
      tb_cs_n <= 1'b0;
      for (int i = 0; i < n[j]; i++) begin
        repeat (4) @(posedge clk_sys);
        tb_sck <= ~tb_sck;
      end
      repeat (4) @(posedge clk_sys);
      tb_cs_n <= 1'b1;
      wait_done(d0, 20, c);
      chk({7'h0, c < 20}, 8'h01, "slave completion");
      if (j == 0) begin
        chk(cap, rev(8'h96), "slave wire order");
        axr(4'hC);
        chk(rd, 8'h96, "slave received byte");
      end
      axr(4'h0);
      chk({7'h0, rd[0]}, {7'h0, j == 1}, "incomplete flag");
      axr(4'h8);
      chk({7'h0, rd[0]}, 8'h01, "slave done flag");
      axw(4'h8, 8'h04);
      axw(4'h0, 8'hA2);
    end
    axw(4'h0, 8'h00);
    $display("test slave done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_other;
    t_master;
    t_slave;
    stop_test;
  end
  // Whole run needs well under this span
  initial begin
    #200000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule

// ### sspi_clkgen.sv
// Master serial clock tick generator: half-period ticks per selected source
`timescale 1ns/1ps
`include "sspi_defs.svh"
module sspi_clkgen (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [2:0] mode,
  input wire logic sub_clk,
  input wire logic tmr_match,
  output logic tick
);
  logic [7:0] cnt_reg;
  logic [7:0] half;
  logic sub_d_reg;
  logic ext_ev;

  always_comb begin
    unique case (mode)
      `SSPI_MODE_DIV16: half = `SSPI_HALF_DIV16;
      `SSPI_MODE_DIV64: half = `SSPI_HALF_DIV64;
      default: half = `SSPI_HALF_DIV4;
    endcase
  end

  // Sub-clock: each edge is one half period; timer: each match is one half period
  assign ext_ev = (mode == `SSPI_MODE_SUB) ? (sub_clk != sub_d_reg) : tmr_match;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sub_d_reg <= 1'b0;
    end else begin
      sub_d_reg <= sub_clk;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !run) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == half) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  always_comb begin
    if (mode == `SSPI_MODE_SUB || mode == `SSPI_MODE_TMR) begin
      tick = run && ext_ev;
    end else begin
      tick = run && (cnt_reg == half);
    end
  end
endmodule

// ### sspi_core.sv
// Serial module SPI core with AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sspi_defs.svh"
module sspi_core (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sub_clk,
  input wire logic tmr_match,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic scs_n_in,
  output logic scs_n_out,
  output logic scs_n_oe,
  output logic done_pulse
);
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] data_reg;
  sspi_pkg::sspi_state_t state_reg;
  logic [3:0] bits_reg;
  logic sck_reg;
  logic sck_d_reg;
  logic scs_d_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [3:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wr_go;
  logic wr_data;
  logic [2:0] mode;
  logic enabled;
  logic is_master;
  logic is_slave;
  logic sel_active;
  logic tick;
  logic edge_lead;
  logic edge_trail;
  logic sample;
  logic shift;
  logic start;
  logic finish;
  logic abort;
  logic sh_load;
  logic [7:0] sh_data;
  logic sh_dout;
  logic cpha;
  logic [7:0] rd_word;
  logic armed_reg;

  assign mode = ctrl0_reg[`SSPI_C0_MODE_HI:`SSPI_C0_MODE_LO];
  assign enabled = ctrl0_reg[`SSPI_C0_EN];
  // Two-wire and unused codes leave this core idle; registers stay shared
  assign is_master = enabled && (mode <= `SSPI_MODE_TMR);
  assign is_slave = enabled && (mode == `SSPI_MODE_SLAVE);
  assign sel_active = !ctrl2_reg[`SSPI_C2_CHIP_SELECT_ENABLE] || !scs_d_reg;
  assign cpha = ctrl2_reg[`SSPI_C2_EDGE] ^ ctrl2_reg[`SSPI_C2_POL];

  function automatic logic [7:0] lane(input logic [31:0] w, input logic [7:0] old, input logic s);
    lane = s ? w[7:0] : old;
  endfunction

  // AXI4-Lite write channel: address and data taken in either order
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_data = wr_go && (awaddr_reg == `SSPI_OFS_DATA);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wbyte_reg <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSPI_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_hold_reg <= 1'b1;
        wbyte_reg <= lane(s_axi_wdata, 8'h00, s_axi_wstrb[0]);
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SSPI_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Link state machine
  assign start = (state_reg == sspi_pkg::SSPI_IDLE) && ((is_master && wr_data)
                 || (is_slave && sel_active && (sck_d_reg != sck_in)));
  assign abort = is_slave && ctrl2_reg[`SSPI_C2_CHIP_SELECT_ENABLE] && scs_d_reg
                 && (state_reg != sspi_pkg::SSPI_IDLE) && (state_reg != sspi_pkg::SSPI_DONE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sck_d_reg <= 1'b0;
      scs_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_in;
      scs_d_reg <= scs_n_in;
    end
  end

  // Output pin lags the shifter by one cycle; a lead edge right after start would sample a stale bit
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= (state_reg != sspi_pkg::SSPI_IDLE);
    end
  end

  // Master: internal ticks toggle the clock; slave: edges of the external clock
  always_comb begin
    edge_lead = 1'b0;
    edge_trail = 1'b0;
    if (is_master) begin
      edge_lead = tick && armed_reg && (state_reg == sspi_pkg::SSPI_LEAD);
      edge_trail = tick && (state_reg == sspi_pkg::SSPI_TRAIL);
    end else if (is_slave && sel_active) begin
      edge_lead = (sck_in != sck_d_reg) && (sck_in == !ctrl2_reg[`SSPI_C2_POL]);
      edge_trail = (sck_in != sck_d_reg) && (sck_in == ctrl2_reg[`SSPI_C2_POL]);
    end
  end

  // Edge select picks which clock edge samples; the other edge shifts
  assign sample = cpha ? edge_trail : edge_lead;
  assign shift = cpha ? (edge_lead && bits_reg != 4'h0) : edge_trail;
  assign finish = (bits_reg == `SSPI_BITS) && (state_reg != sspi_pkg::SSPI_IDLE)
                  && (state_reg != sspi_pkg::SSPI_DONE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !enabled) begin
      state_reg <= sspi_pkg::SSPI_IDLE;
      bits_reg <= 4'h0;
      sck_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        sspi_pkg::SSPI_IDLE: begin
          sck_reg <= ctrl2_reg[`SSPI_C2_POL];
          bits_reg <= 4'h0;
          // A slave starts on the external lead edge itself, so it next waits for a trail edge
          if (start) begin
            state_reg <= is_slave ? sspi_pkg::SSPI_TRAIL : sspi_pkg::SSPI_LEAD;
          end
        end
        sspi_pkg::SSPI_LEAD: begin
          if (abort) begin
            state_reg <= sspi_pkg::SSPI_DONE;
          end else if (finish) begin
            state_reg <= sspi_pkg::SSPI_DONE;
          end else if (edge_lead) begin
            if (is_master) begin
              sck_reg <= !sck_reg;
            end
            state_reg <= sspi_pkg::SSPI_TRAIL;
          end
        end
        sspi_pkg::SSPI_TRAIL: begin
          if (abort) begin
            state_reg <= sspi_pkg::SSPI_DONE;
          end else if (edge_trail) begin
            if (is_master) begin
              sck_reg <= !sck_reg;
            end
            bits_reg <= bits_reg + 4'h1;
            state_reg <= sspi_pkg::SSPI_LEAD;
          end
        end
        sspi_pkg::SSPI_DONE: begin
          state_reg <= sspi_pkg::SSPI_IDLE;
        end
      endcase
    end
  end

  // Master loads on the data write; an idle slave keeps its first bit at the shifter output while deselected, with sdo_oe low
  assign sh_load = (state_reg == sspi_pkg::SSPI_IDLE)
                   && (is_master ? wr_data : (wr_data || (is_slave && !sel_active)));

  sspi_shifter u_shifter (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(sh_load),
    .load_data(wr_data ? wbyte_reg : data_reg),
    .lsb_first(!ctrl2_reg[`SSPI_C2_ORDER]),
    .sample(sample),
    .shift(shift),
    .din(sdi),
    .dout(sh_dout),
    .data(sh_data)
  );

  sspi_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(is_master && (state_reg == sspi_pkg::SSPI_LEAD || state_reg == sspi_pkg::SSPI_TRAIL)),
    .mode(mode),
    .sub_clk(sub_clk),
    .tmr_match(tmr_match),
    .tick(tick)
  );

  // Control and data registers; hardware set wins over software write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl0_reg <= `SSPI_CTRL0_RST;
      ctrl1_reg <= 8'h00;
      ctrl2_reg <= `SSPI_CTRL2_RST;
      data_reg <= `SSPI_DATA_RST;
    end else begin
      if (wr_go && awaddr_reg == `SSPI_OFS_CTRL0) begin
        ctrl0_reg <= wbyte_reg & `SSPI_C0_WMASK;
      end
      if (wr_go && awaddr_reg == `SSPI_OFS_CTRL1) begin
        ctrl1_reg <= wbyte_reg;
      end
      if (wr_go && awaddr_reg == `SSPI_OFS_CTRL2) begin
        ctrl2_reg <= wbyte_reg;
      end
      if (wr_data) begin
        data_reg <= wbyte_reg;
        if (state_reg != sspi_pkg::SSPI_IDLE) begin
          ctrl2_reg[`SSPI_C2_WRITE_COLLISION_FLAG] <= 1'b1;
        end
      end
      if (finish) begin
        data_reg <= sh_data;
        ctrl2_reg[`SSPI_C2_TRF] <= 1'b1;
      end
      if (abort) begin
        ctrl0_reg[`SSPI_C0_ICF] <= 1'b1;
        ctrl2_reg[`SSPI_C2_TRF] <= 1'b1;
      end
    end
  end

  // Read channel
  always_comb begin
    unique case ({s_axi_araddr[3:2], 2'h0})
      `SSPI_OFS_CTRL0: rd_word = ctrl0_reg;
      `SSPI_OFS_CTRL1: rd_word = ctrl1_reg;
      `SSPI_OFS_CTRL2: rd_word = ctrl2_reg;
      default: rd_word = data_reg;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSPI_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_word};
        s_axi_rresp <= `SSPI_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pin drivers, all registered; one select pin only, extra selects use spare pins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      scs_n_out <= 1'b1;
      scs_n_oe <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      sck_out <= sck_reg;
      sck_oe <= is_master;
      sdo <= sh_dout;
      sdo_oe <= is_master || (is_slave && sel_active);
      scs_n_out <= !(state_reg == sspi_pkg::SSPI_LEAD || state_reg == sspi_pkg::SSPI_TRAIL);
      scs_n_oe <= is_master && ctrl2_reg[`SSPI_C2_CHIP_SELECT_ENABLE];
      done_pulse <= finish || abort;
    end
  end
endmodule

// ### sspi_core_props.sv
// Port-level assertions for the serial core
`timescale 1ns/1ps
module sspi_core_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic scs_n_in,
  input wire logic scs_n_out,
  input wire logic scs_n_oe,
  input wire logic done_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Clock edges of the current byte while the core drives the clock
  logic [4:0] tog_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n || done_pulse || !sck_oe) begin
      tog_reg <= 5'h00;
    end else if ($changed(sck_out)) begin
      tog_reg <= tog_reg + 5'h01;
    end
  end
  property p_sck_master;
    $changed(sck_out) |-> sck_oe || $past(sck_oe);
  endproperty
  a_sck_master: assert property (p_sck_master) else $error("clock moved while not master");
  property p_sck_spacing;
    $changed(sck_out) |=> $stable(sck_out);
  endproperty
  a_sck_spacing: assert property (p_sck_spacing) else $error("clock half period below two cycles");
  property p_clk_sel;
    $changed(sck_out) && scs_n_oe |-> !scs_n_out || !$past(scs_n_out);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock moved with select high");
  property p_cs_master;
    scs_n_oe |-> sck_oe;
  endproperty
  a_cs_master: assert property (p_cs_master) else $error("select driven outside master mode");
  property p_done_pulse;
    done_pulse |=> !done_pulse;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_eight;
    done_pulse && sck_oe |-> tog_reg + 5'($changed(sck_out)) == 5'h10;
  endproperty
  a_eight: assert property (p_eight) else $error("master byte not sixteen clock edges");
  property p_sdo_sel;
    sdo_oe && !sck_oe |-> !scs_n_in || !$past(scs_n_in) || !$past(scs_n_in, 2);
  endproperty
  a_sdo_sel: assert property (p_sdo_sel) else $error("slave drives output while deselected");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped or changed");
  c_master: cover property (done_pulse && sck_oe);
  c_slave: cover property (done_pulse && !sck_oe);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind sspi_core sspi_core_props sspi_core_props_i (.clk_sys, .reset_n, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .sck_out, .sck_oe, .sdo_oe, .scs_n_in, .scs_n_out, .scs_n_oe, .done_pulse);

// ### sspi_defs.svh
// Register offsets, field positions, reset values and mode codes of the serial module
`ifndef SSPI_DEFS_SVH
`define SSPI_DEFS_SVH
`define SSPI_OFS_CTRL0 4'h0
`define SSPI_OFS_CTRL1 4'h4
`define SSPI_OFS_CTRL2 4'h8
`define SSPI_OFS_DATA 4'hC
`define SSPI_CTRL0_RST 8'hE0
`define SSPI_CTRL2_RST 8'h00
`define SSPI_DATA_RST 8'h00
`define SSPI_C0_MODE_HI 7
`define SSPI_C0_MODE_LO 5
`define SSPI_C0_DEB_HI 3
`define SSPI_C0_DEB_LO 2
`define SSPI_C0_EN 1
`define SSPI_C0_ICF 0
`define SSPI_C2_POL 5
`define SSPI_C2_EDGE 4
`define SSPI_C2_ORDER 3
`define SSPI_C2_CHIP_SELECT_ENABLE 2
`define SSPI_C2_WRITE_COLLISION_FLAG 1
`define SSPI_C2_TRF 0
`define SSPI_C0_WMASK 8'hEF
`define SSPI_MODE_DIV4 3'h0
`define SSPI_MODE_DIV16 3'h1
`define SSPI_MODE_DIV64 3'h2
`define SSPI_MODE_SUB 3'h3
`define SSPI_MODE_TMR 3'h4
`define SSPI_MODE_SLAVE 3'h5
`define SSPI_MODE_TWI 3'h6
`define SSPI_HALF_DIV4 8'h01
`define SSPI_HALF_DIV16 8'h07
`define SSPI_HALF_DIV64 8'h1F
`define SSPI_BITS 4'h8
`define SSPI_RESP_OKAY 2'h0
`define SSPI_RESP_SLVERR 2'h2
`endif

// ### sspi_peer.sv
// Far-side peripheral: echoes what it hears while selected, records wire bits
`timescale 1ns/1ps
module sspi_peer (
  input wire logic clk_sys,
  input wire logic sck,
  input wire logic sdo,
  input wire logic scs_n,
  output logic sdi,
  output logic [7:0] cap,
  output logic [4:0] ntog
);
  logic sck_q = 1'b0;
  logic sdo_q = 1'b0;
  logic cs_q = 1'b1;
  logic [4:0] n;
  initial cap = 8'h00;
  initial ntog = 5'h00;
  // Sample the line as it stood before each second clock edge; valid for either phase
  always @(posedge clk_sys) begin
    n = (cs_q && !scs_n) ? 5'h00 : ntog;
    if (!scs_n && sck != sck_q) begin
      if (n[0]) cap <= {cap[6:0], sdo_q};
      n = n + 5'h01;
    end
    ntog <= n;
    sck_q <= sck;
    sdo_q <= sdo;
    cs_q <= scs_n;
  end
  // Deselected output shows the inverse so a stale bit cannot pass
  assign sdi = !scs_n ? sdo : ~sdo_q;
endmodule

// ### sspi_pkg.sv
// Types shared by the serial module files
package sspi_pkg;
  typedef enum logic [3:0] {
    SSPI_IDLE = 4'h1,
    SSPI_LEAD = 4'h2,
    SSPI_TRAIL = 4'h4,
    SSPI_DONE = 4'h8
  } sspi_state_t;
endpackage

// ### sspi_shifter.sv
// Eight-bit full duplex shift register with selectable bit order
`timescale 1ns/1ps
`include "sspi_defs.svh"
module sspi_shifter (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic lsb_first,
  input wire logic sample,
  input wire logic shift,
  input wire logic din,
  output logic dout,
  output logic [7:0] data
);
  logic [7:0] sr_reg;
  logic in_bit_reg;

  assign dout = lsb_first ? sr_reg[0] : sr_reg[7];
  assign data = sr_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      in_bit_reg <= 1'b0;
    end else if (sample) begin
      in_bit_reg <= din;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sr_reg <= `SSPI_DATA_RST;
    end else if (load) begin
      sr_reg <= load_data;
    end else if (shift) begin
      if (lsb_first) begin
        sr_reg <= {in_bit_reg, sr_reg[7:1]};
      end else begin
        sr_reg <= {sr_reg[6:0], in_bit_reg};
      end
    end
  end
endmodule
